// *** hdl/mpsr_top.sv ***
// register slice: filter bypass, peak capture, primary event flags
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module mpsr_top
  import mpsr_pkg::*;
#(
  parameter bit HAS_FUND = 1'b1,
  parameter bit HAS_REACTIVE = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // filter control to signal path
  output logic hpf_bypass,
  // peak detector results
  input wire logic cur_peak_stb,
  input wire logic [MAG_W-1:0] cur_peak_mag,
  input wire logic [2:0] cur_peak_phase,
  input wire logic volt_peak_stb,
  input wire logic [MAG_W-1:0] volt_peak_mag,
  input wire logic [2:0] volt_peak_phase,
  // bit 30 of each per-phase energy accumulator
  input wire logic [2:0] tot_act_bit30,
  input wire logic [2:0] fund_act_bit30,
  input wire logic [2:0] tot_react_bit30,
  input wire logic [2:0] fund_react_bit30,
  input wire logic [2:0] apparent_bit30,
  // line cycle timing
  input wire logic half_cycle_tick,
  // power signs, high when negative
  input wire logic [2:0] tot_act_neg,
  input wire logic [2:0] fund_act_neg,
  input wire logic [2:0] tot_react_neg,
  input wire logic [2:0] fund_react_neg,
  input wire logic sum1_neg,
  // interrupt
  output logic irq
);

  // ==========================================================
  // helpers

  // true when any bit of a three-phase group moved
  function automatic logic any_flip(input logic [2:0] now_v, input logic [2:0] old_v);
    any_flip = |(now_v ^ old_v);
  endfunction : any_flip

  // write hit on a given address
  function automatic logic wr_hit(input logic [15:0] a);
    wr_hit = reg_wr && (reg_addr == a);
  endfunction : wr_hit

  // ==========================================================
  // software registers
  // every word resets to zero; a write to any other address leaves it alone

  logic [23:0] filter_bypass_r;
  logic [7:0] accum_cfg_r;
  logic [FLAG_W-1:0] event_mask_r;
  logic line_mode_r;
  logic [HALF_CYC_W-1:0] half_cyc_set_r;

  // filter bypass word, any nonzero value counts
  // only the low 24 bits are kept; the rest of a written word is dropped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      filter_bypass_r <= FILTER_BYPASS_RST;
    end else if (wr_hit(ADDR_FILTER_BYPASS)) begin
      filter_bypass_r <= reg_wdata[23:0];
    end
  end

  // bypass level from its own flop, loaded beside the word so both agree;
  // zero keeps filters in, anything else bypasses all of them
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hpf_bypass <= 1'b0;
    end else if (wr_hit(ADDR_FILTER_BYPASS)) begin
      hpf_bypass <= |reg_wdata[23:0];
    end
  end

  // accumulation config, sign source selects live here
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      accum_cfg_r <= ACCUM_CFG_RST;
    end else if (wr_hit(ADDR_ACCUM_CFG)) begin
      accum_cfg_r <= reg_wdata[7:0];
    end
  end

  // interrupt mask, same layout as the flags
  // a masked flag still sets and reads back; it only stays off the interrupt
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      event_mask_r <= FLAGS_RST;
    end else if (wr_hit(ADDR_EVENT_MASK)) begin
      event_mask_r <= reg_wdata[FLAG_W-1:0];
    end
  end

  // line-cycle mode enable; turning it off also restarts the count
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      line_mode_r <= 1'b0;
    end else if (wr_hit(ADDR_LINE_CTRL)) begin
      line_mode_r <= reg_wdata[LINE_EN_BIT];
    end
  end

  // number of half line cycles per integration
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      half_cyc_set_r <= HALF_CYC_RST;
    end else if (wr_hit(ADDR_HALF_CYC)) begin
      half_cyc_set_r <= reg_wdata[HALF_CYC_W-1:0];
    end
  end

  // ==========================================================
  // peak capture
  // the detectors outside find the peaks; each word holds the last result and
  // its phase tag until the next strobe replaces both together

  logic [MAG_W-1:0] cur_mag_r;
  logic [2:0] cur_phase_r;
  logic [MAG_W-1:0] volt_mag_r;
  logic [2:0] volt_phase_r;

  // current channel peak and its phase tag
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_mag_r <= '0;
      cur_phase_r <= '0;
    end else if (cur_peak_stb) begin
      cur_mag_r <= cur_peak_mag;
      cur_phase_r <= cur_peak_phase;
    end
  end

  // voltage channel peak and its phase tag
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      volt_mag_r <= '0;
      volt_phase_r <= '0;
    end else if (volt_peak_stb) begin
      volt_mag_r <= volt_peak_mag;
      volt_phase_r <= volt_peak_phase;
    end
  end

  // ==========================================================
  // energy bit-30 watch

  logic primed_r;
  logic [2:0] tot_act_old_r;
  logic [2:0] fund_act_old_r;
  logic [2:0] tot_react_old_r;
  logic [2:0] fund_react_old_r;
  logic [2:0] apparent_old_r;

  // primed stays low for the first edge after reset, so a live accumulator
  // bit that differs from the cleared history is not taken as a change
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      primed_r <= 1'b0;
    end else begin
      primed_r <= 1'b1;
    end
  end

  // last total active bits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tot_act_old_r <= '0;
    end else begin
      tot_act_old_r <= tot_act_bit30;
    end
  end

  // last fundamental active bits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fund_act_old_r <= '0;
    end else begin
      fund_act_old_r <= fund_act_bit30;
    end
  end

  // last total reactive bits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tot_react_old_r <= '0;
    end else begin
      tot_react_old_r <= tot_react_bit30;
    end
  end

  // last fundamental reactive bits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fund_react_old_r <= '0;
    end else begin
      fund_react_old_r <= fund_react_bit30;
    end
  end

  // last apparent bits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      apparent_old_r <= '0;
    end else begin
      apparent_old_r <= apparent_bit30;
    end
  end

  // ==========================================================
  // line-cycle integration
  // flag 5 rises on the edge of the Nth half-cycle tick; the count then restarts

  logic [HALF_CYC_W-1:0] half_cnt_r;
  logic line_done;

  // limitation: a new setting takes effect at once; one below the count already
  // reached lets the counter run until it wraps before the next completion
  // count half cycles while line mode runs; a zero setting never ends
  assign line_done = line_mode_r && half_cycle_tick && (half_cyc_set_r != HALF_CYC_RST)
                     && (half_cnt_r == half_cyc_set_r - 16'h0001);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      half_cnt_r <= HALF_CYC_RST;
    end else if (!line_mode_r || line_done) begin
      half_cnt_r <= HALF_CYC_RST;
    end else if (half_cycle_tick) begin
      half_cnt_r <= half_cnt_r + 16'h0001;
    end
  end

  // ==========================================================
  // power sign tracking
  // sign bits are 1 for negative power

  logic [SIGN_W-1:0] sign_r;
  logic [SIGN_W-1:0] sign_nxt;

  // selected signs: active by one select bit, reactive by another; a variant
  // without fundamental metering ignores the selects and follows total power
  always_comb begin
    sign_nxt = SIGN_RST;
    sign_nxt[SG_ACT +: 3] = (HAS_FUND && accum_cfg_r[ACT_SEL_BIT]) ? fund_act_neg : tot_act_neg;
    sign_nxt[SG_SUM1] = sum1_neg;
    if (HAS_REACTIVE) begin
      sign_nxt[SG_REACT +: 3] = (HAS_FUND && accum_cfg_r[REACT_SEL_BIT]) ? fund_react_neg : tot_react_neg;
    end
  end

  // the sign word always shows the present sign
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sign_r <= SIGN_RST;
    end else begin
      sign_r <= sign_nxt;
    end
  end

  // ==========================================================
  // event flags
  // every event is a one-cycle set pulse; the word keeps it until cleared

  logic [FLAG_W-1:0] flag_set;
  logic [FLAG_W-1:0] flag_clr;
  logic [FLAG_W-1:0] flags_r;
  logic [FLAG_W-1:0] flags_nxt;
  logic [FLAG_W-1:0] event_mask_nxt;
  logic [SIGN_W-1:0] sign_flip;

  // a select change may also register as a flip, as in a real meter
  assign sign_flip = primed_r ? (sign_nxt ^ sign_r) : SIGN_RST;

  // raw events, one cycle each
  always_comb begin
    flag_set = FLAGS_RST;
    flag_set[FL_TOT_ACT] = primed_r && any_flip(tot_act_bit30, tot_act_old_r);
    flag_set[FL_FUND_ACT] = HAS_FUND && primed_r && any_flip(fund_act_bit30, fund_act_old_r);
    flag_set[FL_TOT_REACT] = HAS_REACTIVE && primed_r && any_flip(tot_react_bit30, tot_react_old_r);
    flag_set[FL_FUND_REACT] = HAS_FUND && HAS_REACTIVE && primed_r
                              && any_flip(fund_react_bit30, fund_react_old_r);
    flag_set[FL_APPARENT] = primed_r && any_flip(apparent_bit30, apparent_old_r);
    flag_set[FL_LINE_DONE] = line_done;
    flag_set[FL_ACT_FLIP +: 3] = sign_flip[SG_ACT +: 3];
    flag_set[FL_SUM1_FLIP] = sign_flip[SG_SUM1];
    flag_set[FL_REACT_FLIP +: 2] = sign_flip[SG_REACT +: 2];
    flag_set[FL_REACT_FLIP + 2] = sign_flip[SG_REACT + 2];
  end

  // write-one-to-clear
  assign flag_clr = wr_hit(ADDR_EVENT_FLAGS) ? reg_wdata[FLAG_W-1:0] : FLAGS_RST;

  // next flag word; a new event beats a clear in the same cycle, so an event
  // that lands while software clears its bit is never lost
  assign flags_nxt = (flags_r & ~flag_clr) | flag_set;

  // sticky flags
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ==========================================================
  // interrupt

  // mask as it will stand after this edge
  assign event_mask_nxt = wr_hit(ADDR_EVENT_MASK) ? reg_wdata[FLAG_W-1:0] : event_mask_r;

  // level interrupt from a flop, fed from next values so that it rises on the
  // same edge as its flag rather than one cycle behind
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags_nxt & event_mask_nxt);
    end
  end

  // ==========================================================
  // read path
  // the word stands for exactly one cycle after the strobe and the port shows
  // zero otherwise, so a host that samples late sees zero rather than old data

  logic [31:0] rd_mux;

  // unmapped addresses and reserved bits read zero
  always_comb begin
    rd_mux = READ_ZERO;
    case (reg_addr)
      ADDR_FILTER_BYPASS: rd_mux[23:0] = filter_bypass_r;
      ADDR_CUR_PEAK: begin
        rd_mux[MAG_W-1:0] = cur_mag_r;
        rd_mux[PHASE_LSB +: 3] = cur_phase_r;
      end
      ADDR_VOLT_PEAK: begin
        rd_mux[MAG_W-1:0] = volt_mag_r;
        rd_mux[PHASE_LSB +: 3] = volt_phase_r;
      end
      ADDR_EVENT_FLAGS: rd_mux[FLAG_W-1:0] = flags_r;
      ADDR_SIGN_WORD: rd_mux[SIGN_W-1:0] = sign_r;
      ADDR_ACCUM_CFG: rd_mux[7:0] = accum_cfg_r;
      ADDR_EVENT_MASK: rd_mux[FLAG_W-1:0] = event_mask_r;
      ADDR_LINE_CTRL: rd_mux[LINE_EN_BIT] = line_mode_r;
      ADDR_HALF_CYC: rd_mux[HALF_CYC_W-1:0] = half_cyc_set_r;
      default: rd_mux = READ_ZERO;
    endcase
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= READ_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= READ_ZERO;
    end
  end

endmodule : mpsr_top

// *** common/mpsr_pkg.sv ***
// constants of the metering peak and status register slice
// Summary of operation
// - zero bypass word keeps all filters active
// - any nonzero bypass word bypasses every filter
// - current peak magnitude in low 24 bits
// - bits 24-26 tag current peak phase
// - peak register top five bits read zero
// - voltage peak magnitude in low 24 bits
// - bits 24-26 tag voltage peak phase
// - flag 0 on total active bit-30 change
// - flag 1 on fundamental active bit-30 change
// - flag 2 on total reactive bit-30 change
// - flag 3 on fundamental reactive bit-30 change
// - flag 4 on apparent energy bit-30 change
// - flag 5 ends line-cycle integration
// - flags 6-8 on phase active sign flip
// - flag 9 on pulse-one sum sign flip
// - flags 10-11 on A/B reactive flip
// - flag 12 on phase C reactive flip
package mpsr_pkg;
  // ==========================================================
  // register offsets
  localparam logic [15:0] ADDR_FILTER_BYPASS = 16'h43B6;
  localparam logic [15:0] ADDR_CUR_PEAK = 16'hE500;
  localparam logic [15:0] ADDR_VOLT_PEAK = 16'hE501;
  localparam logic [15:0] ADDR_EVENT_FLAGS = 16'hE502;
  localparam logic [15:0] ADDR_SIGN_WORD = 16'hE617;
  localparam logic [15:0] ADDR_ACCUM_CFG = 16'hE701;
  localparam logic [15:0] ADDR_EVENT_MASK = 16'hE5F0;
  localparam logic [15:0] ADDR_LINE_CTRL = 16'hE5F1;
  localparam logic [15:0] ADDR_HALF_CYC = 16'hE5F2;
  // ==========================================================
  // widths and field positions
  localparam int MAG_W = 24;
  localparam int FLAG_W = 13;
  localparam int SIGN_W = 7;
  localparam int HALF_CYC_W = 16;
  localparam int PHASE_LSB = 24;
  localparam int ACT_SEL_BIT = 6;
  localparam int REACT_SEL_BIT = 7;
  localparam int LINE_EN_BIT = 0;
  // event flag positions
  localparam int FL_TOT_ACT = 0;
  localparam int FL_FUND_ACT = 1;
  localparam int FL_TOT_REACT = 2;
  localparam int FL_FUND_REACT = 3;
  localparam int FL_APPARENT = 4;
  localparam int FL_LINE_DONE = 5;
  localparam int FL_ACT_FLIP = 6;
  localparam int FL_SUM1_FLIP = 9;
  localparam int FL_REACT_FLIP = 10;
  // sign word positions
  localparam int SG_ACT = 0;
  localparam int SG_SUM1 = 3;
  localparam int SG_REACT = 4;
  // ==========================================================
  // reset values
  localparam logic [23:0] FILTER_BYPASS_RST = 24'h000000;
  localparam logic [7:0] ACCUM_CFG_RST = 8'h00;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 13'h0000;
  localparam logic [SIGN_W-1:0] SIGN_RST = 7'h00;
  localparam logic [HALF_CYC_W-1:0] HALF_CYC_RST = 16'h0000;
  localparam logic [31:0] READ_ZERO = 32'h00000000;
endpackage : mpsr_pkg

// *** bench/mpsr_props.sv ***
// checker for the metering register slice ports
`timescale 1ns/1ps
module mpsr_props
  import mpsr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // watched side signals
  input wire logic hpf_bypass,
  input wire logic cur_peak_stb,
  input wire logic [MAG_W-1:0] cur_peak_mag,
  input wire logic [2:0] cur_peak_phase,
  input wire logic volt_peak_stb,
  input wire logic [MAG_W-1:0] volt_peak_mag,
  input wire logic [2:0] volt_peak_phase,
  input wire logic [2:0] tot_act_bit30
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // load, one quiet cycle, then a read of the captured word
  sequence s_cur_rd;
    cur_peak_stb ##1 !cur_peak_stb ##1 (reg_rd && reg_addr == ADDR_CUR_PEAK && !cur_peak_stb);
  endsequence
  sequence s_volt_rd;
    volt_peak_stb ##1 !volt_peak_stb ##1 (reg_rd && reg_addr == ADDR_VOLT_PEAK && !volt_peak_stb);
  endsequence
  // accumulator bit change, then the flag word is read
  sequence s_act_rd;
    $changed(tot_act_bit30) ##1 (reg_rd && reg_addr == ADDR_EVENT_FLAGS);
  endsequence
  property p_byp_on;
    reg_wr && reg_addr == ADDR_FILTER_BYPASS && reg_wdata[23:0] != 24'h000000 |=> hpf_bypass;
  endproperty
  property p_byp_off;
    reg_wr && reg_addr == ADDR_FILTER_BYPASS && reg_wdata[23:0] == 24'h000000 |=> !hpf_bypass;
  endproperty
  property p_cur;
    s_cur_rd |=> reg_rdata[26:0] == {$past(cur_peak_phase, 3), $past(cur_peak_mag, 3)};
  endproperty
  property p_volt;
    s_volt_rd |=> reg_rdata[26:0] == {$past(volt_peak_phase, 3), $past(volt_peak_mag, 3)};
  endproperty
  property p_top;
    reg_rd && (reg_addr == ADDR_CUR_PEAK || reg_addr == ADDR_VOLT_PEAK) |=> reg_rdata[31:27] == 5'h00;
  endproperty
  property p_act;
    s_act_rd |=> reg_rdata[FL_TOT_ACT];
  endproperty
  property p_flag_hi;
    reg_rd && reg_addr == ADDR_EVENT_FLAGS |=> reg_rdata[31:13] == 19'h00000;
  endproperty
  property p_idle;
    !reg_rd |=> reg_rdata == 32'h00000000;
  endproperty
  a_byp_on: assert property (p_byp_on) else $error("bypass not raised");
  a_byp_off: assert property (p_byp_off) else $error("bypass not cleared");
  a_cur: assert property (p_cur) else $error("current peak word wrong");
  a_volt: assert property (p_volt) else $error("voltage peak word wrong");
  a_top: assert property (p_top) else $error("peak top bits not zero");
  a_act: assert property (p_act) else $error("active energy flag missing");
  a_flag_hi: assert property (p_flag_hi) else $error("flag upper bits set");
  a_idle: assert property (p_idle) else $error("read data outside read slot");
endmodule : mpsr_props

bind mpsr_top mpsr_props u_mpsr_props (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .hpf_bypass, .cur_peak_stb, .cur_peak_mag, .cur_peak_phase, .volt_peak_stb, .volt_peak_mag,
  .volt_peak_phase, .tot_act_bit30);

// *** bench/mpsr_host_model.sv ***
// host model driving the register port
`timescale 1ns/1ps
module mpsr_host_model (
  // clock
  input wire logic clk,
  // register port
  output logic [15:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  // quiet bus from time zero
  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one-cycle write; stale data inverted so a late sample cannot match
  task wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  // one-cycle read, data taken in the following cycle only
  task rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
endmodule : mpsr_host_model

// *** bench/mpsr_tb_top.sv ***
// testbench of the metering register slice
`timescale 1ns/1ps
module mpsr_tb_top
  import mpsr_pkg::*;
;
  logic clk, arst_n, reg_wr, reg_rd, hpf_bypass, irq, sum1_neg, half_cycle_tick, cur_peak_stb, volt_peak_stb;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [23:0] cur_peak_mag, volt_peak_mag;
  logic [2:0] cur_peak_phase, volt_peak_phase, tot_act_bit30, fund_act_bit30, tot_react_bit30;
  logic [2:0] fund_react_bit30, apparent_bit30, tot_act_neg, fund_act_neg, tot_react_neg, fund_react_neg;
  logic [14:0] e30;
  logic [12:0] sg;
  logic [31:0] byp [4] = '{32'h00000001, 32'h00800000, 32'hFF000000, 32'h00000000};
  int err_total, comparisons, sb;
  // event inputs packed for table-driven toggling
  assign {apparent_bit30, fund_react_bit30, tot_react_bit30, fund_act_bit30, tot_act_bit30} = e30;
  assign {sum1_neg, fund_react_neg, tot_react_neg, fund_act_neg, tot_act_neg} = sg;
  // ==========================================================
  // design and host
  mpsr_top u_mpsr_top (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .hpf_bypass,
    .cur_peak_stb, .cur_peak_mag, .cur_peak_phase, .volt_peak_stb, .volt_peak_mag, .volt_peak_phase,
    .tot_act_bit30, .fund_act_bit30, .tot_react_bit30, .fund_react_bit30, .apparent_bit30, .half_cycle_tick,
    .tot_act_neg, .fund_act_neg, .tot_react_neg, .fund_react_neg, .sum1_neg, .irq);
  mpsr_host_model u_mpsr_host_model (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========================================================
  // helpers
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task rdc(input logic [15:0] a, input logic [31:0] exp, input string nm);
    u_mpsr_host_model.rd(a, d);
    chk(nm, d, exp);
  endtask : rdc
  // both detectors load at once; voltage gets inverted data to tell them apart
  task peak(input logic [23:0] m, input logic [2:0] p);
    @(posedge clk);
    cur_peak_stb <= 1'b1;
    volt_peak_stb <= 1'b1;
    cur_peak_mag <= m;
    volt_peak_mag <= ~m;
    cur_peak_phase <= p;
    volt_peak_phase <= ~p;
    @(posedge clk);
    cur_peak_stb <= 1'b0;
    volt_peak_stb <= 1'b0;
  endtask : peak
  task end_sim;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  // watchdog well beyond the roughly 190 cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    end_sim();
  end
  // ==========================================================
  // main sequence
  initial begin
    arst_n = 1'b0;
    e30 = 15'h0000;
    sg = 13'h0000;
    half_cycle_tick = 1'b0;
    cur_peak_stb = 1'b0;
    volt_peak_stb = 1'b0;
    cur_peak_mag = 24'h000000;
    volt_peak_mag = 24'h000000;
    cur_peak_phase = 3'h0;
    volt_peak_phase = 3'h0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    // reset values, plus an unmapped place
    rdc(ADDR_FILTER_BYPASS, 32'h00000000, "bypass reset");
    rdc(ADDR_CUR_PEAK, 32'h00000000, "cur reset");
    rdc(ADDR_VOLT_PEAK, 32'h00000000, "volt reset");
    rdc(ADDR_EVENT_FLAGS, 32'h00000000, "flags reset");
    rdc(16'h1234, 32'h00000000, "unmapped");
    // bypass word: only bits 23:0 count
    for (int i = 0; i < 4; i++) begin
      u_mpsr_host_model.wr(ADDR_FILTER_BYPASS, byp[i]);
      #1 chk("bypass", {31'h0, hpf_bypass}, {31'h0, byp[i][23:0] != 24'h000000});
      rdc(ADDR_FILTER_BYPASS, byp[i] & 32'h00FFFFFF, "bypass word");
    end
    // peaks; writes to the read-only words are ignored
    peak(24'hABCDEF, 3'b100);
    rdc(ADDR_CUR_PEAK, 32'h04ABCDEF, "cur peak");
    rdc(ADDR_VOLT_PEAK, 32'h03543210, "volt peak");
    peak(24'h000000, 3'b001);
    rdc(ADDR_VOLT_PEAK, 32'h06FFFFFF, "volt peak");
    u_mpsr_host_model.wr(ADDR_CUR_PEAK, 32'hFFFFFFFF);
    rdc(ADDR_CUR_PEAK, 32'h01000000, "cur peak");
    // energy half flags: sticky, only written ones clear
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) e30[i * 3 + i % 3] <= ~e30[i * 3 + i % 3];
      rdc(ADDR_EVENT_FLAGS, 32'h00000001 << i, "energy flag");
      u_mpsr_host_model.wr(ADDR_EVENT_FLAGS, ~(32'h00000001 << i));
      rdc(ADDR_EVENT_FLAGS, 32'h00000001 << i, "flag kept");
      u_mpsr_host_model.wr(ADDR_EVENT_FLAGS, 32'h00000001 << i);
      rdc(ADDR_EVENT_FLAGS, 32'h00000000, "flag cleared");
    end
    // interrupt: raised by an unmasked flag only
    u_mpsr_host_model.wr(ADDR_EVENT_MASK, 32'h00000001);
    @(posedge clk) e30[0] <= ~e30[0];
    @(posedge clk) e30[3] <= ~e30[3];
    #1 chk("irq on", {31'h0, irq}, 32'h00000001);
    u_mpsr_host_model.wr(ADDR_EVENT_FLAGS, 32'h00000001);
    #1 chk("irq masked", {31'h0, irq}, 32'h00000000);
    u_mpsr_host_model.wr(ADDR_EVENT_FLAGS, 32'h00000002);
    // sign flips of total powers, sign word accumulating
    for (int j = 0; j < 7; j++) begin
      sb = j < 3 ? j : (j == 3 ? 12 : j + 2);
      @(posedge clk) sg[sb] <= 1'b1;
      rdc(ADDR_EVENT_FLAGS, 32'h00000040 << j, "sign flag");
      rdc(ADDR_SIGN_WORD, (32'h00000002 << j) - 32'h00000001, "sign word");
      u_mpsr_host_model.wr(ADDR_EVENT_FLAGS, 32'hFFFFFFFF);
    end
    // unselected fundamental flips quietly; selecting it flips B and C
    @(posedge clk) sg[3] <= 1'b1;
    rdc(ADDR_EVENT_FLAGS, 32'h00000000, "unselected");
    u_mpsr_host_model.wr(ADDR_ACCUM_CFG, 32'h00000040);
    rdc(ADDR_EVENT_FLAGS, 32'h00000180, "select flip");
    rdc(ADDR_SIGN_WORD, 32'h00000079, "select sign");
    u_mpsr_host_model.wr(ADDR_EVENT_FLAGS, 32'hFFFFFFFF);
    // line cycle over three half cycles
    u_mpsr_host_model.wr(ADDR_HALF_CYC, 32'h00000003);
    u_mpsr_host_model.wr(ADDR_LINE_CTRL, 32'h00000001);
    for (int k = 1; k < 4; k++) begin
      @(posedge clk) half_cycle_tick <= 1'b1;
      @(posedge clk) half_cycle_tick <= 1'b0;
      rdc(ADDR_EVENT_FLAGS, k == 3 ? 32'h00000020 : 32'h00000000, "line done");
    end
    // mid-run reset with live inputs: bypass drops, no false flags on release
    u_mpsr_host_model.wr(ADDR_FILTER_BYPASS, 32'h00000100);
    @(posedge clk) arst_n <= 1'b0;
    @(posedge clk) arst_n <= 1'b1;
    #1 chk("bypass after reset", {31'h0, hpf_bypass}, 32'h00000000);
    rdc(ADDR_SIGN_WORD, 32'h0000007F, "sign after reset");
    rdc(ADDR_EVENT_FLAGS, 32'h00000000, "flags after reset");
    end_sim();
  end
endmodule : mpsr_tb_top
